// [cix_core.sv]
`default_nettype none
module cix_core
  import cix_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // File read data for the operand addressed by the command
  input wire logic [7:0] file_rdata_i,
  // Top of return stack value
  input wire logic [14:0] top_of_return_stack_i,
  // Core state outputs
  output cix_fwrite_t file_write_o,
  output logic [4:0] bank_selection_register_o,
  output logic [6:0] program_counter_high_latch_o,
  output logic [14:0] pc_o,
  output logic stack_pop_o,
  output logic [7:0] option_o,
  output logic [7:0] port_a_direction_o,
  output logic [7:0] port_b_direction_o,
  output logic [7:0] port_c_direction_o,
  output logic watchdog_clear_o,
  output logic device_reset_o,
  output logic sleep_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } cix_state_t;

  cix_state_t state;
  logic [31:0] cmd;
  logic [1:0] wait_cnt;
  logic [7:0] work;
  cix_status_t status;
  logic [15:0] ptr [2];

  // Decoded command fields
  cix_op_t op;
  logic dest_file;
  logic psel;
  logic [1:0] mode;
  logic [6:0] faddr;
  logic [7:0] lit;
  logic [5:0] offs;
  assign op = cix_op_t'(cmd[CMD_OP_LSB +: 5]);
  assign dest_file = cmd[CMD_DEST_BIT];
  assign psel = cmd[CMD_PTR_SEL_BIT];
  assign mode = cmd[CMD_MODE_LSB +: 2];
  assign faddr = cmd[CMD_FILE_LSB +: 7];
  assign lit = cmd[7:0];
  assign offs = cmd[5:0];

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  // Subtract operands and borrow-in; carry means no borrow
  logic [7:0] sub_a;
  logic sub_bin;
  logic [8:0] sub_full;
  logic [4:0] sub_low;
  always_comb
  begin
    sub_a = (op == OP_SUBTRACT_FROM_LITERAL) ? lit : file_rdata_i;
    sub_bin = (op == OP_SUBTRACT_WITH_BORROW) ? ~status.carry : 1'b0;
    sub_full = {1'b0, sub_a} - {1'b0, work} - {8'h00, sub_bin};
    sub_low = {1'b0, sub_a[3:0]} - {1'b0, work[3:0]} - {4'h0, sub_bin};
  end

  // Pointer arithmetic wraps naturally in 16 bits
  logic [15:0] ptr_cur;
  logic [15:0] ptr_step;
  logic [15:0] ptr_rel;
  always_comb
  begin
    ptr_cur = ptr[psel];
    ptr_step = mode[0] ? ptr_cur - 16'h0001 : ptr_cur + 16'h0001;
    ptr_rel = ptr_cur + {{10{offs[5]}}, offs};
  end

  // Result and destination
  logic [7:0] result;
  logic res_valid;
  logic res_flags;
  logic next_c;
  logic next_dc;
  always_comb
  begin
    result = 8'h00;
    res_valid = 1'b0;
    res_flags = 1'b0;
    next_c = status.carry;
    next_dc = status.digit_carry_flag;
    case (op)
      OP_ROTATE_LEFT_CARRY:
      begin
        result = {file_rdata_i[6:0], status.carry};
        next_c = file_rdata_i[7];
        res_valid = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY:
      begin
        result = {status.carry, file_rdata_i[7:1]};
        next_c = file_rdata_i[0];
        res_valid = 1'b1;
      end
      OP_SUBTRACT_FROM_LITERAL, OP_SUBTRACT_FROM_FILE, OP_SUBTRACT_WITH_BORROW:
      begin
        result = sub_full[7:0];
        next_c = ~sub_full[8];
        next_dc = ~sub_low[4];
        res_valid = 1'b1;
        res_flags = 1'b1;
      end
      OP_SWAP_NIBBLES:
      begin
        result = {file_rdata_i[3:0], file_rdata_i[7:4]};
        res_valid = 1'b1;
      end
      OP_XOR_LITERAL:
      begin
        result = work ^ lit;
        res_valid = 1'b1;
      end
      OP_XOR_FILE:
      begin
        result = work ^ file_rdata_i;
        res_valid = 1'b1;
      end
      default:
      begin
        result = 8'h00;
      end
    endcase
  end

  // Which results go to the file instead of W
  logic to_file;
  assign to_file = dest_file && (op != OP_SUBTRACT_FROM_LITERAL) && (op != OP_XOR_LITERAL);

  // ----------------------------------------------------------------
  // Sequencer: one cycle per instruction, returns hold for two
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      state <= ST_IDLE;
      cmd <= 32'h0000_0000;
      wait_cnt <= 2'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          // The acknowledging edge still shows the finished command; take only stalled ones
          if (avs_write_i && avs_address_i == ADDR_CMD && avs_waitrequest_o
              && !status.sleeping)
          begin
            cmd <= avs_writedata_i;
            state <= ST_EXEC;
          end
        ST_EXEC:
          // Returns spend a second cycle, like the flushed fetch
          if (op == OP_RETURN_FROM_IRQ || op == OP_RETURN_FROM_SUB
              || op == OP_RETURN_WITH_LITERAL)
          begin
            wait_cnt <= RETURN_CYCLES - 2'h1;
            state <= ST_WAIT;
          end
          else
          begin
            state <= ST_DONE;
          end
        ST_WAIT:
          if (wait_cnt == 2'h1)
          begin
            state <= ST_DONE;
          end
          else
          begin
            wait_cnt <= wait_cnt - 2'h1;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Bus handshake: a command write stalls until executed, or is acknowledged unexecuted while asleep
  logic cmd_stall;
  assign cmd_stall = avs_write_i && avs_address_i == ADDR_CMD && state != ST_DONE
    && !status.sleeping;
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      // Waitrequest is registered, so every access takes at least one stall cycle
      avs_waitrequest_o <= !(avs_waitrequest_o == 1'b1 && (avs_read_i || avs_write_i)
        && !cmd_stall);
      if (avs_address_i == ADDR_WORK)
      begin
        avs_readdata_o <= {24'h000000, work};
      end
      else if (avs_address_i == ADDR_STATUS)
      begin
        avs_readdata_o <= {24'h000000, status};
      end
      else if (avs_address_i == ADDR_PTR)
      begin
        avs_readdata_o <= {ptr[1], ptr[0]};
      end
      else
      begin
        avs_readdata_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Working register and status
  // ----------------------------------------------------------------
  logic exec;
  assign exec = (state == ST_EXEC);
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      work <= 8'h00;
      status <= '{default: 1'b0, reset_instruction_flag: 1'b1, timeout_flag: 1'b1,
                  power_down_flag: 1'b1};
    end
    else if (exec)
    begin
      if (op == OP_LOAD_WORK_LITERAL || op == OP_RETURN_WITH_LITERAL)
      begin
        work <= lit;
      end
      else if (res_valid && !to_file)
      begin
        work <= result;
      end
      if (res_valid)
      begin
        status.carry <= next_c;
        status.digit_carry_flag <= next_dc;
        if (res_flags || op == OP_XOR_LITERAL || op == OP_XOR_FILE)
        begin
          status.zero <= (result == 8'h00);
        end
      end
      if (op == OP_RETURN_FROM_IRQ)
      begin
        status.global_interrupt_enable <= 1'b1;
      end
      if (op == OP_SLEEP)
      begin
        status.timeout_flag <= 1'b1;
        status.power_down_flag <= 1'b0;
        status.sleeping <= 1'b1;
      end
      if (op == OP_SOFT_RESET)
      begin
        // Reset clears the core state but keeps the cause visible
        work <= 8'h00;
        status <= '{default: 1'b0, timeout_flag: 1'b1, power_down_flag: 1'b1};
      end
    end
    else if (avs_write_i && avs_address_i == ADDR_STATUS && !avs_waitrequest_o)
    begin
      // Software wakes the core and may set the reset indicator again
      status.sleeping <= avs_writedata_i[7];
      status.reset_instruction_flag <= status.reset_instruction_flag | avs_writedata_i[5];
    end
  end

  // ----------------------------------------------------------------
  // File select pointers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ptr
      always_ff @(posedge sys_clk_i)
      begin
        if (srst_i || (exec && op == OP_SOFT_RESET))
        begin
          ptr[gi] <= 16'h0000;
        end
        else if (exec && op == OP_STORE_WORK_INDIRECT && psel == gi[0])
        begin
          ptr[gi] <= ptr_step;
        end
        else if (avs_write_i && avs_address_i == ADDR_PTR && !avs_waitrequest_o)
        begin
          ptr[gi] <= avs_writedata_i[16 * gi +: 16];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // File writes, including the redirected indirect store
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      file_write_o <= '0;
    end
    else
    begin
      file_write_o.valid <= 1'b0;
      if (exec && op == OP_STORE_WORK_TO_FILE)
      begin
        file_write_o <= '{valid: 1'b1, addr: {9'h000, faddr}, data: work};
      end
      else if (exec && op == OP_STORE_WORK_INDIRECT)
      begin
        // Pre modes use the stepped value, post modes the old one
        file_write_o <= '{valid: 1'b1, addr: mode[1] ? ptr_cur : ptr_step,
                          data: work};
      end
      else if (exec && op == OP_STORE_WORK_RELATIVE)
      begin
        file_write_o <= '{valid: 1'b1, addr: ptr_rel, data: work};
      end
      else if (exec && res_valid && to_file)
      begin
        file_write_o <= '{valid: 1'b1, addr: {9'h000, faddr}, data: result};
      end
    end
  end

  // ----------------------------------------------------------------
  // Special registers and control strobes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || (exec && op == OP_SOFT_RESET))
    begin
      bank_selection_register_o <= 5'h00;
      program_counter_high_latch_o <= 7'h00;
      option_o <= OPTION_RESET;
      port_a_direction_o <= DIR_RESET;
      port_b_direction_o <= DIR_RESET;
      port_c_direction_o <= DIR_RESET;
    end
    else if (exec)
    begin
      if (op == OP_LOAD_BANK_LITERAL)
      begin
        bank_selection_register_o <= lit[4:0];
      end
      if (op == OP_LOAD_PAGE_LATCH_LITERAL)
      begin
        program_counter_high_latch_o <= lit[6:0];
      end
      if (op == OP_LOAD_OPTION)
      begin
        option_o <= work;
      end
      if (op == OP_LOAD_PORT_DIRECTION)
      begin
        // Other selectors are ignored
        if (faddr == DIR_SEL_A)
        begin
          port_a_direction_o <= work;
        end
        else if (faddr == DIR_SEL_B)
        begin
          port_b_direction_o <= work;
        end
        else if (faddr == DIR_SEL_C)
        begin
          port_c_direction_o <= work;
        end
      end
    end
  end

  // Program counter, one-cycle strobes and the sleep output
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      pc_o <= 15'h0000;
      stack_pop_o <= 1'b0;
      watchdog_clear_o <= 1'b0;
      device_reset_o <= 1'b0;
      sleep_o <= 1'b0;
    end
    else
    begin
      stack_pop_o <= 1'b0;
      watchdog_clear_o <= exec && op == OP_SLEEP;
      device_reset_o <= exec && op == OP_SOFT_RESET;
      sleep_o <= status.sleeping;
      if (exec && (op == OP_RETURN_FROM_IRQ || op == OP_RETURN_FROM_SUB
          || op == OP_RETURN_WITH_LITERAL))
      begin
        pc_o <= top_of_return_stack_i;
        stack_pop_o <= 1'b1;
      end
      else if (exec && op == OP_SOFT_RESET)
      begin
        pc_o <= 15'h0000;
      end
      else if (exec)
      begin
        pc_o <= pc_o + 15'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// [cix_pkg.sv]
package cix_pkg;

  // ----------------------------------------------------------------
  // Operation codes (local encoding of the decoded operation)
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_LOAD_BANK_LITERAL = 5'h01,
    OP_LOAD_PAGE_LATCH_LITERAL = 5'h02,
    OP_LOAD_WORK_LITERAL = 5'h03,
    OP_STORE_WORK_TO_FILE = 5'h04,
    OP_STORE_WORK_INDIRECT = 5'h05,
    OP_STORE_WORK_RELATIVE = 5'h06,
    OP_LOAD_OPTION = 5'h07,
    OP_SOFT_RESET = 5'h08,
    OP_RETURN_FROM_IRQ = 5'h09,
    OP_RETURN_FROM_SUB = 5'h0a,
    OP_RETURN_WITH_LITERAL = 5'h0b,
    OP_ROTATE_LEFT_CARRY = 5'h0c,
    OP_ROTATE_RIGHT_CARRY = 5'h0d,
    OP_SUBTRACT_FROM_LITERAL = 5'h0e,
    OP_SUBTRACT_FROM_FILE = 5'h0f,
    OP_SUBTRACT_WITH_BORROW = 5'h10,
    OP_SLEEP = 5'h11,
    OP_SWAP_NIBBLES = 5'h12,
    OP_LOAD_PORT_DIRECTION = 5'h13,
    OP_XOR_LITERAL = 5'h14,
    OP_XOR_FILE = 5'h15
  } cix_op_t;

  // ----------------------------------------------------------------
  // Command word layout at the byte addresses of the bus
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_WORK = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_PTR = 4'hc;
  localparam int CMD_OP_LSB = 24;
  localparam int CMD_DEST_BIT = 23;
  localparam int CMD_PTR_SEL_BIT = 22;
  localparam int CMD_MODE_LSB = 20;
  localparam int CMD_FILE_LSB = 8;
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;
  localparam logic [6:0] DIR_SEL_A = 7'h05;
  localparam logic [6:0] DIR_SEL_B = 7'h06;
  localparam logic [6:0] DIR_SEL_C = 7'h07;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [1:0] RETURN_CYCLES = 2'h2;

  // Status bits seen by software
  typedef struct packed {
    logic sleeping;
    logic global_interrupt_enable;
    logic reset_instruction_flag;
    logic timeout_flag;
    logic power_down_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } cix_status_t;

  // File write request to data memory
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } cix_fwrite_t;

endpackage

// [cix_mem_model.sv]
`default_nettype none
module cix_mem_model
  import cix_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Core side
  input wire cix_fwrite_t file_write_i,
  input wire logic [6:0] rd_addr_i,
  input wire logic stack_pop_i,
  output logic [7:0] file_rdata_o,
  output logic [14:0] top_of_return_stack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  logic [15:0] last_addr;
  logic [7:0] last_data;

  // Writes land at the pointed address; only its low byte indexes the array
  always @(posedge sys_clk_i)
  begin
    if (file_write_i.valid === 1'b1)
    begin
      mem[file_write_i.addr[7:0]] <= file_write_i.data;
      last_addr <= file_write_i.addr;
      last_data <= file_write_i.data;
    end
  end

  // Stack top moves on each pop so that two returns never see one address
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
      top_of_return_stack_o <= 15'h1234;
    else if (stack_pop_i === 1'b1)
      top_of_return_stack_o <= top_of_return_stack_o + 15'h0111;
  end

  // Operand is the file register named by the command
  assign file_rdata_o = mem[{1'b0, rd_addr_i}];
endmodule
`default_nettype wire

// [cix_core_sva.sv]
`default_nettype none
module cix_core_sva
  import cix_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Bus side
  input wire logic [3:0] avs_address_i,
  input wire logic avs_write_i,
  // Core side
  input wire logic [14:0] top_of_return_stack_i,
  input wire cix_fwrite_t file_write_o,
  input wire logic [14:0] pc_o,
  input wire logic stack_pop_o,
  input wire logic [7:0] option_o,
  input wire logic [7:0] port_a_direction_o,
  input wire logic [7:0] port_b_direction_o,
  input wire logic [7:0] port_c_direction_o,
  input wire logic watchdog_clear_o,
  input wire logic device_reset_o,
  input wire logic sleep_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cmd_wr;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  // A command write in progress is the only legal cause of file writes and option changes
  assign cmd_wr = avs_write_i && (avs_address_i == ADDR_CMD);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_pop_loads_pc;
    stack_pop_o |-> pc_o == top_of_return_stack_i;
  endproperty
  a_pop_loads_pc: assert property (p_pop_loads_pc)
    else $error("pc not taken from stack top");
  property p_pop_pulse;
    stack_pop_o |=> !stack_pop_o;
  endproperty
  a_pop_pulse: assert property (p_pop_pulse)
    else $error("stack pop longer than one cycle");
  property p_reset_pc;
    device_reset_o |-> pc_o == 15'h0000;
  endproperty
  a_reset_pc: assert property (p_reset_pc)
    else $error("pc not cleared by soft reset");
  property p_wdc_sleep;
    watchdog_clear_o |=> sleep_o;
  endproperty
  a_wdc_sleep: assert property (p_wdc_sleep)
    else $error("watchdog clear without sleep");
  property p_sleep_halt;
    sleep_o && $past(sleep_o) |-> $stable(pc_o);
  endproperty
  a_sleep_halt: assert property (p_sleep_halt)
    else $error("pc moved while asleep");
  property p_fw_pulse;
    file_write_o.valid |=> !file_write_o.valid;
  endproperty
  a_fw_pulse: assert property (p_fw_pulse)
    else $error("file write longer than one cycle");
  property p_fw_cause;
    file_write_o.valid |-> $past(cmd_wr);
  endproperty
  a_fw_cause: assert property (p_fw_cause)
    else $error("file write outside a command");
  property p_opt_cause;
    $changed(option_o) |-> $past(cmd_wr);
  endproperty
  a_opt_cause: assert property (p_opt_cause)
    else $error("option changed outside a command");
  property p_dir_one;
    !device_reset_o |-> $onehot0({$changed(port_a_direction_o),
      $changed(port_b_direction_o), $changed(port_c_direction_o)});
  endproperty
  a_dir_one: assert property (p_dir_one)
    else $error("more than one direction register changed");
endmodule

bind cix_core cix_core_sva u_cix_core_sva (
  .sys_clk_i(sys_clk_i),
  .srst_i(srst_i),
  .avs_address_i(avs_address_i),
  .avs_write_i(avs_write_i),
  .top_of_return_stack_i(top_of_return_stack_i),
  .file_write_o(file_write_o),
  .pc_o(pc_o),
  .stack_pop_o(stack_pop_o),
  .option_o(option_o),
  .port_a_direction_o(port_a_direction_o),
  .port_b_direction_o(port_b_direction_o),
  .port_c_direction_o(port_c_direction_o),
  .watchdog_clear_o(watchdog_clear_o),
  .device_reset_o(device_reset_o),
  .sleep_o(sleep_o)
);
`default_nettype wire

// [cix_core_bench.sv]
`default_nettype none
module cix_core_bench
  import cix_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 0, srst_i = 1, rd = 0, wr = 0, wreq, pop, wdc, drst, slp;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, tmp, st;
  logic [7:0] frd, opt, pa, pb, pcd, wm;
  logic [14:0] top_of_return_stack, pc, t;
  logic [15:0] p, ea, np;
  logic [4:0] bank_selection_register;
  logic [6:0] pch;
  cix_fwrite_t fw;
  int errors = 0, n_checks = 0, n_pop = 0, n_wdc = 0, n_rst = 0, lat, l1;
  cix_op_t rops [3] = '{OP_RETURN_FROM_IRQ, OP_RETURN_FROM_SUB, OP_RETURN_WITH_LITERAL};
  // Layout: dest, op, file value, W, literal
  logic [31:0] tbl [16] = '{32'h0ce60000, 32'h8c800000, 32'h0d010000, 32'h8d020000,
    32'h0e001110, 32'h0e002222, 32'h8f300f00, 32'h0f050900, 32'h10101000,
    32'h0e000001, 32'h90050400, 32'h12a50000, 32'h923c0000, 32'h1400ffff,
    32'h950ff000, 32'h15555500};

  cix_core u_cix_core (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .file_rdata_i(frd), .top_of_return_stack_i(top_of_return_stack),
    .file_write_o(fw), .bank_selection_register_o(bank_selection_register), .program_counter_high_latch_o(pch),
    .pc_o(pc), .stack_pop_o(pop), .option_o(opt), .port_a_direction_o(pa),
    .port_b_direction_o(pb), .port_c_direction_o(pcd), .watchdog_clear_o(wdc),
    .device_reset_o(drst), .sleep_o(slp));
  cix_mem_model u_cix_mem_model (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .file_write_i(fw), .rd_addr_i(wd[14:8]), .stack_pop_i(pop), .file_rdata_o(frd),
    .top_of_return_stack_o(top_of_return_stack));

  initial
  begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // Pulses last one cycle, so they are counted rather than sampled by tasks
  always @(posedge sys_clk_i)
  begin
    n_pop <= n_pop + int'(pop === 1'b1);
    n_wdc <= n_wdc + int'(wdc === 1'b1);
    n_rst <= n_rst + int'(drst === 1'b1);
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // The request stands until a rising edge samples waitrequest low; read data
  // is taken at that same edge and the request is dropped right after it
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q, output int n);
    n = 0;
    @(posedge sys_clk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100)
      errors++;
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic cmd(input cix_op_t op, input logic [23:0] lo);
    acc(1'b1, ADDR_CMD, {3'h0, op, lo}, tmp, lat);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    int n;
    acc(1'b0, a, 32'h0, tmp, n);
    chk(tmp, e);
  endtask

  // Reference for the operate group; carry and zero come from the status model
  task automatic alu(input logic [31:0] e);
    logic [7:0] f, k, w, a, r;
    logic [8:0] d;
    logic [4:0] h;
    logic bi;
    cix_op_t op;
    op = cix_op_t'(e[28:24]);
    f = e[23:16];
    w = e[15:8];
    k = e[7:0];
    cmd(OP_LOAD_WORK_LITERAL, {16'h0, w});
    u_cix_mem_model.mem[8'h20] = f;
    cmd(op, {e[31], 8'h0, 7'h20, k});
    a = (op == OP_SUBTRACT_FROM_LITERAL) ? k : f;
    bi = (op == OP_SUBTRACT_WITH_BORROW) && !st[0];
    d = {1'b0, a} - {1'b0, w} - 9'(bi);
    h = {1'b0, a[3:0]} - {1'b0, w[3:0]} - 5'(bi);
    case (op)
      OP_ROTATE_LEFT_CARRY:
      begin
        r = {f[6:0], st[0]};
        st[0] = f[7];
      end
      OP_ROTATE_RIGHT_CARRY:
      begin
        r = {st[0], f[7:1]};
        st[0] = f[0];
      end
      OP_SWAP_NIBBLES: r = {f[3:0], f[7:4]};
      OP_XOR_LITERAL: r = w ^ k;
      OP_XOR_FILE: r = w ^ f;
      default:
      begin
        r = d[7:0];
        st[1:0] = {!h[4], !d[8]};
      end
    endcase
    if (op != OP_SWAP_NIBBLES && op != OP_ROTATE_LEFT_CARRY && op != OP_ROTATE_RIGHT_CARRY)
      st[2] = (r == 8'h0);
    wm = e[31] ? w : r;
    if (e[31])
      chk(u_cix_mem_model.last_data, r);
    rchk(ADDR_WORK, wm);
    rchk(ADDR_STATUS, st);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    st = 32'h38;
    cmd(OP_LOAD_BANK_LITERAL, 24'h1f);
    chk(bank_selection_register, 32'h1f);
    cmd(OP_LOAD_PAGE_LATCH_LITERAL, 24'h7f);
    chk(pch, 32'h7f);
    cmd(OP_LOAD_WORK_LITERAL, 24'h5a);
    l1 = lat;
    rchk(ADDR_WORK, 32'h5a);
    rchk(ADDR_STATUS, st);
    cmd(OP_STORE_WORK_TO_FILE, 24'h7f00);
    chk(u_cix_mem_model.last_addr[6:0], 32'h7f);
    chk(u_cix_mem_model.last_data, 32'h5a);
    $display("test direct loads done");
    for (int s = 0; s < 2; s++)
      for (int m = 0; m < 4; m++)
      begin
        p = s ? 16'h0000 : 16'hffff;
        acc(1'b1, ADDR_PTR, 32'h0000ffff, tmp, lat);
        cmd(OP_STORE_WORK_INDIRECT, {1'b0, s[0], m[1:0], 20'h0});
        ea = m[1] ? p : (m[0] ? p - 16'h1 : p + 16'h1);
        np = m[0] ? p - 16'h1 : p + 16'h1;
        chk(u_cix_mem_model.last_addr, ea);
        chk(u_cix_mem_model.last_data, 32'h5a);
        rchk(ADDR_PTR, s ? {np, 16'hffff} : {16'h0, np});
      end
    acc(1'b1, ADDR_PTR, 32'h00100010, tmp, lat);
    cmd(OP_STORE_WORK_RELATIVE, 24'h000020);
    chk(u_cix_mem_model.last_addr, 32'hfff0);
    cmd(OP_STORE_WORK_RELATIVE, 24'h40001f);
    chk(u_cix_mem_model.last_addr, 32'h002f);
    rchk(ADDR_PTR, 32'h00100010);
    rchk(ADDR_STATUS, st);
    $display("test indirect done");
    cmd(OP_LOAD_WORK_LITERAL, 24'h4f);
    cmd(OP_LOAD_OPTION, 24'h0);
    chk(opt, 32'h4f);
    for (int d = 5; d < 8; d++)
    begin
      cmd(OP_LOAD_WORK_LITERAL, {16'h0, 8'h30 + 8'(d)});
      cmd(OP_LOAD_PORT_DIRECTION, {9'h0, 7'(d), 8'h0});
    end
    chk({pa, pb, pcd}, 32'h353637);
    $display("test option and direction done");
    for (int i = 0; i < 3; i++)
    begin
      t = top_of_return_stack;
      cmd(rops[i], 24'h0000a5);
      chk(pc, t);
      chk(lat, l1 + 1);
    end
    chk(n_pop, 32'h3);
    rchk(ADDR_WORK, 32'ha5);
    st = st | 32'h40;
    rchk(ADDR_STATUS, st);
    $display("test returns done");
    foreach (tbl[i])
      alu(tbl[i]);
    $display("test operate group done");
    cmd(OP_SLEEP, 24'h0);
    chk(slp, 32'h1);
    chk(n_wdc, 32'h1);
    st = (st | 32'h90) & 32'hf7;
    rchk(ADDR_STATUS, st);
    cmd(OP_LOAD_WORK_LITERAL, 24'h77);
    rchk(ADDR_WORK, wm);
    acc(1'b1, ADDR_STATUS, 32'h0, tmp, lat);
    // Wake lands at the acknowledge edge; the sleep output follows one edge later
    repeat (2) @(posedge sys_clk_i);
    chk(slp, 32'h0);
    rchk(4'h1, 32'h0);
    $display("test sleep done");
    cmd(OP_SOFT_RESET, 24'h0);
    chk(n_rst, 32'h1);
    chk(pc, 32'h0);
    chk(opt, 32'hff);
    rchk(ADDR_STATUS, 32'h18);
    rchk(ADDR_WORK, 32'h0);
    $display("test soft reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
